// *** bwbr_window_regs.sv ***
`timescale 1ns/1ns
`default_nettype none

`include "bwbr_defs.svh"

module bwbr_window_regs #(
    parameter int LUT_LOG = 6  // Log2 of lookup table entries
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Configuration access
    input  wire logic                  cfg_secondary,
    input  wire logic [7:0]            cfg_addr,
    input  wire logic                  cfg_wr,
    input  wire logic                  cfg_rd,
    input  wire logic [3:0]            cfg_be,
    input  wire bwbr_pkg::bwbr_word_t  cfg_wdata,
    output logic                       cfg_rvalid,
    output bwbr_pkg::bwbr_word_t       cfg_rdata,
    // Companion registers kept elsewhere
    input  wire bwbr_pkg::bwbr_word_t  ds_upper_setup,
    input  wire bwbr_pkg::bwbr_word_t  ds_lower_setup,
    input  wire bwbr_pkg::bwbr_word_t  ds_lower_base,
    input  wire bwbr_pkg::bwbr_page_code_t page_code,
    // Downstream claim
    input  wire logic                  ds_req,
    input  wire logic [63:0]           ds_addr,
    output logic                       ds_claim,
    output logic                       ds_enabled,
    // Upstream claim and translation
    input  wire logic                  us_req,
    input  wire bwbr_pkg::bwbr_word_t  us_addr,
    output logic                       us_claim,
    output logic [LUT_LOG-1:0]         us_lut_index,
    input  wire bwbr_pkg::bwbr_word_t  lut_xlat_base,
    input  wire logic                  lut_prefetch,
    output logic                       us_xlat_valid,
    output bwbr_pkg::bwbr_word_t       us_xlat_addr,
    output logic                       us_prefetch,
    output logic                       us_enabled
);
    import bwbr_pkg::*;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    bwbr_reg_if ds_if ();  // Upper half of downstream window
    bwbr_reg_if us_if ();  // Upstream translated window

    bwbr_bit_store u_ds_store (
        .clk (clk),
        .rst (rst),
        .bus (ds_if)
    );

    bwbr_bit_store u_us_store (
        .clk (clk),
        .rst (rst),
        .bus (us_if)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    bwbr_sel_e sel;  // Register chosen by this access
    logic [7:0] ofs;  // Dword aligned byte offset

    assign ofs = {cfg_addr[7:2], 2'h0};

    // The two spaces place the registers at swapped offsets
    always_comb begin
        sel = BWBR_SEL_NONE;
        if (!cfg_secondary) begin
            // Primary space
            if (ofs == `BWBR_DS_UPPER_PRI_OFS) begin
                sel = BWBR_SEL_DS_UPPER;
            end else if (ofs == `BWBR_US_XLAT_PRI_OFS) begin
                sel = BWBR_SEL_US_XLAT;
            end
        end else begin
            // Secondary space
            if (ofs == `BWBR_DS_UPPER_SEC_OFS) begin
                sel = BWBR_SEL_DS_UPPER;
            end else if (ofs == `BWBR_US_XLAT_SEC_OFS) begin
                sel = BWBR_SEL_US_XLAT;
            end
        end
    end

    // ------------------------------------------------------------
    // Downstream upper half
    // ------------------------------------------------------------
    // Setup bits pass straight through as the writeable mask
    assign ds_if.wr    = cfg_wr && (sel == BWBR_SEL_DS_UPPER);
    assign ds_if.be    = cfg_be;
    assign ds_if.wdata = cfg_wdata;
    assign ds_if.mask  = ds_upper_setup;

    // ------------------------------------------------------------
    // Upstream window size
    // ------------------------------------------------------------
    logic       us_en;    // Window enabled by a nonzero code
    logic [4:0] win_log;  // Log2 of window size in bytes
    logic [4:0] page_log; // Log2 of one table page
    bwbr_word_t win_mask; // Writeable base bits
    bwbr_word_t page_mask;// Offset bits kept inside a page

    // Code zero disables; code n gives a 2^(13+n) byte window
    assign us_en    = (page_code != `BWBR_PAGE_CODE_OFF);
    assign win_log  = `BWBR_US_MIN_LOG + {1'h0, page_code};
    assign page_log = win_log - 5'(LUT_LOG);

    genvar b;
    generate
        for (b = 0; b < 32; b = b + 1) begin : g_mask
            // Base bits at and above the window size are writeable
            if (b >= `BWBR_US_BASE_LSB) begin : g_base
                assign win_mask[b] = us_en && (5'(b) >= win_log);
            end else begin : g_low
                assign win_mask[b] = 1'h0;
            end
            // Offset bits below the page size pass untranslated
            assign page_mask[b] = (5'(b) < page_log);
        end
    endgenerate

    assign us_if.wr    = cfg_wr && (sel == BWBR_SEL_US_XLAT);
    assign us_if.be    = cfg_be;
    assign us_if.wdata = cfg_wdata;
    assign us_if.mask  = win_mask & `BWBR_US_BASE_MASK;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    bwbr_word_t rd_word;  // Selected read value
    bwbr_word_t us_word;  // Upstream register as software sees it

    // Space, type and low bits stay zero; prefetchable only when on
    always_comb begin
        us_word = us_if.value;
        us_word[`BWBR_US_SPACE_BIT] = 1'b0;
        us_word[2:1] = 2'h0;
        us_word[13:4] = 10'h000;
        us_word[`BWBR_US_PREF_BIT] = us_en;
    end

    // Unmapped offsets read as zero
    always_comb begin
        case (sel)
            BWBR_SEL_DS_UPPER: begin
                rd_word = ds_if.value;
            end
            BWBR_SEL_US_XLAT: begin
                rd_word = us_word;
            end
            default: begin
                rd_word = `BWBR_RESET_WORD;
            end
        endcase
    end

    // Read answer registers, one per concern
    logic       rvalid_ff;  // Read answer strobe
    bwbr_word_t rdata_ff;   // Read answer word

    // Answer strobe follows the read strobe by exactly one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Nothing outstanding after reset
            rvalid_ff <= 1'h0;
        end else begin
            // A write or an idle cycle drops the strobe
            rvalid_ff <= cfg_rd;
        end
    end

    // Only a read refreshes the word, so it holds between reads
    // and a slow master may pick it up late without harm
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Reads zero until the first read
            rdata_ff <= `BWBR_RESET_WORD;
        end else if (cfg_rd) begin
            // Capture the selected register
            rdata_ff <= rd_word;
        end
    end

    // Both answer outputs come straight from flip-flops
    assign cfg_rvalid = rvalid_ff;
    assign cfg_rdata  = rdata_ff;

    // ------------------------------------------------------------
    // Downstream claim
    // ------------------------------------------------------------
    logic       ds_on;     // Window enabled by upper bit 31
    bwbr_word_t lo_mask;   // Compared lower base bits
    logic       ds_hit;    // Address falls inside the window

    assign ds_on = ds_if.value[`BWBR_DS_ENABLE_BIT];
    // Lower half never decodes below the 4 KB minimum
    assign lo_mask = ds_lower_setup & `BWBR_DS_LOWER_MIN_MASK;
    assign ds_hit = ds_on
        && ((ds_addr[63:32] & ds_if.mask) == ds_if.value)
        && ((ds_addr[31:0] & lo_mask)
            == (ds_lower_base & lo_mask));

    // Claim and enable flags registered to keep timing short
    logic nxt_ds_claim;   // Claim decision for this cycle's address
    logic ds_claim_ff;    // Claim answer, one cycle after the request
    logic ds_enabled_ff;  // Window enable as seen by the claim logic

    // A miss or an idle cycle answers with no claim
    assign nxt_ds_claim = ds_req && ds_hit;

    // Claim strobe, one cycle per hitting request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // No claim can be pending out of reset
            ds_claim_ff <= 1'h0;
        end else begin
            ds_claim_ff <= nxt_ds_claim;
        end
    end

    // Enable flag lags the stored bit 31 by one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Stored bit 31 is zero after reset
            ds_enabled_ff <= 1'h0;
        end else begin
            ds_enabled_ff <= ds_on;
        end
    end

    assign ds_claim   = ds_claim_ff;
    assign ds_enabled = ds_enabled_ff;

    // ------------------------------------------------------------
    // Upstream claim and table lookup
    // ------------------------------------------------------------
    logic       us_hit;     // Address inside the upstream window
    bwbr_word_t us_addr_ff; // Address held for translation

    assign us_hit = us_en
        && ((us_addr & us_if.mask) == us_if.value);

    // First stage claims and presents the table index
    logic               nxt_us_claim;   // Hit on this cycle's request
    logic [LUT_LOG-1:0] nxt_lut_index;  // Table page of this address
    logic               us_claim_ff;    // Claim answer
    logic [LUT_LOG-1:0] lut_index_ff;   // Index shown to the table
    logic               us_enabled_ff;  // Window enable, one cycle late

    // The page index sits just above the in-page offset, so its
    // position moves with the page size code
    assign nxt_us_claim  = us_req && us_hit;
    assign nxt_lut_index = us_addr[page_log +: LUT_LOG];

    // Claim strobe, one cycle per hitting request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // No claim pending out of reset
            us_claim_ff <= 1'h0;
        end else begin
            us_claim_ff <= nxt_us_claim;
        end
    end

    // Index and address are kept until the next hit, so a miss
    // never disturbs a translation still in flight
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Point at entry zero with a null address
            lut_index_ff <= '0;
            us_addr_ff   <= `BWBR_RESET_WORD;
        end else if (nxt_us_claim) begin
            // Capture the hitting request
            lut_index_ff <= nxt_lut_index;
            us_addr_ff   <= us_addr;
        end
    end

    // Enable flag lags the page size code by one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Window disabled out of reset
            us_enabled_ff <= 1'h0;
        end else begin
            us_enabled_ff <= us_en;
        end
    end

    assign us_claim     = us_claim_ff;
    assign us_lut_index = lut_index_ff;
    assign us_enabled   = us_enabled_ff;

    // Second stage merges the table base with the page offset.
    // The table answers in the cycle the index is presented.
    logic       xlat_valid_ff;  // Translation strobe
    bwbr_word_t nxt_xlat_addr;  // Merged address from the table
    bwbr_word_t xlat_addr_ff;   // Translated address, held
    logic       nxt_prefetch;   // Page prefetch after the veto
    logic       prefetch_ff;    // Prefetch flag, held

    assign nxt_xlat_addr = (lut_xlat_base & ~page_mask)
                         | (us_addr_ff & page_mask);
    // Window is prefetchable; the entry may veto it
    assign nxt_prefetch  = us_en && lut_prefetch;

    // Translation strobe one cycle after the claim
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xlat_valid_ff <= 1'h0;
        end else begin
            xlat_valid_ff <= us_claim_ff;
        end
    end

    // Changing the page size code with a translation in flight
    // mixes two page sizes; software must quiesce traffic first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xlat_addr_ff <= `BWBR_RESET_WORD;
            prefetch_ff  <= 1'h0;
        end else if (us_claim_ff) begin
            xlat_addr_ff <= nxt_xlat_addr;
            prefetch_ff  <= nxt_prefetch;
        end
    end

    assign us_xlat_valid = xlat_valid_ff;
    assign us_xlat_addr  = xlat_addr_ff;
    assign us_prefetch   = prefetch_ff;

endmodule

`default_nettype wire

// *** bwbr_defs.svh ***
`ifndef BWBR_DEFS_SVH
`define BWBR_DEFS_SVH

// ----------------------------------------------------------------
// Configuration byte offsets (dword aligned)
// ----------------------------------------------------------------
`define BWBR_DS_UPPER_PRI_OFS  8'h24
`define BWBR_DS_UPPER_SEC_OFS  8'h64
`define BWBR_US_XLAT_PRI_OFS   8'h60
`define BWBR_US_XLAT_SEC_OFS   8'h20

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define BWBR_RESET_WORD        32'h00000000
`define BWBR_DS_ENABLE_BIT     31
`define BWBR_US_SPACE_BIT      0
`define BWBR_US_PREF_BIT       3
`define BWBR_US_BASE_LSB       14
`define BWBR_DS_LOWER_MIN_MASK 32'hFFFFF000
`define BWBR_US_BASE_MASK      32'hFFFFC000
`define BWBR_US_MIN_LOG        5'h0D
`define BWBR_PAGE_CODE_OFF     4'h0

`endif

// *** bwbr_pkg.sv ***
`default_nettype none

package bwbr_pkg;

    // One configuration dword
    typedef logic [31:0] bwbr_word_t;

    // Page size code from the chip control register
    typedef logic [3:0]  bwbr_page_code_t;

    // Which register a configuration access selects
    typedef enum logic [1:0] {
        BWBR_SEL_NONE,
        BWBR_SEL_DS_UPPER,
        BWBR_SEL_US_XLAT
    } bwbr_sel_e;

endpackage

`default_nettype wire

// *** bwbr_reg_if.sv ***
`timescale 1ns/1ns
`default_nettype none

// Carries one masked base register between decode and storage
interface bwbr_reg_if;
    logic        wr;     // Write strobe for this register
    logic [3:0]  be;     // Byte enables of the write
    logic [31:0] wdata;  // Write data
    logic [31:0] mask;   // Writeable bits; zero bits read zero
    logic [31:0] value;  // Stored value, already masked

    modport owner (
        output wr,
        output be,
        output wdata,
        output mask,
        input  value
    );

    modport store (
        input  wr,
        input  be,
        input  wdata,
        input  mask,
        output value
    );
endinterface

`default_nettype wire

// *** bwbr_bit_store.sv ***
`timescale 1ns/1ns
`default_nettype none

// Per-bit storage whose writeability follows a mask
module bwbr_bit_store (
    input  wire logic clk,
    input  wire logic rst,
    bwbr_reg_if.store bus
);
    import bwbr_pkg::*;

    // ------------------------------------------------------------
    // Storage bits
    // ------------------------------------------------------------
    bwbr_word_t bit_ff;  // Last written value per bit

    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            // A masked-off bit is cleared, so re-enabling it later
            // never exposes a stale value
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    bit_ff[i] <= 1'h0;
                end else if (!bus.mask[i]) begin
                    bit_ff[i] <= 1'h0;
                end else if (bus.wr && bus.be[i / 8]) begin
                    bit_ff[i] <= bus.wdata[i];
                end
            end
        end
    endgenerate

    // Reads return only writeable bits
    assign bus.value = bit_ff & bus.mask;

endmodule

`default_nettype wire

// *** bwbr_window_regs_props.sv ***
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Port checker for the window base registers
// ------------------------------------------------------------
module bwbr_window_regs_props (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic                      cfg_secondary,
    input wire logic [7:0]                cfg_addr,
    input wire logic                      cfg_rd,
    input wire logic                      cfg_rvalid,
    input wire bwbr_pkg::bwbr_word_t      cfg_rdata,
    input wire bwbr_pkg::bwbr_word_t      ds_upper_setup,
    input wire bwbr_pkg::bwbr_word_t      ds_lower_setup,
    input wire bwbr_pkg::bwbr_word_t      ds_lower_base,
    input wire bwbr_pkg::bwbr_page_code_t page_code,
    input wire logic                      ds_req,
    input wire logic [63:0]               ds_addr,
    input wire logic                      ds_claim,
    input wire logic                      ds_enabled,
    input wire logic                      us_req,
    input wire logic                      us_claim,
    input wire logic                      lut_prefetch,
    input wire logic                      us_xlat_valid,
    input wire logic                      us_prefetch,
    input wire logic                      us_enabled
);
    import bwbr_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff rst;

    // Reads of each register, primary or secondary offset
    wire logic       us_rd = cfg_rd
        && cfg_addr[7:2] == (cfg_secondary ? 6'h08 : 6'h18);
    wire logic       ds_rd = cfg_rd
        && cfg_addr[7:2] == (cfg_secondary ? 6'h19 : 6'h09);
    wire bwbr_word_t ds_low = ds_addr[31:0];  // Lower address half

    property p_rvalid;
        cfg_rvalid == $past(cfg_rd);
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read answer not one cycle after read");

    property p_us_fix;
        us_rd |=> cfg_rdata[2:0] == 3'h0 && cfg_rdata[13:4] == 10'h000
            && cfg_rdata[3] == ($past(page_code) != 4'h0);
    endproperty
    a_us_fix: assert property (p_us_fix)
        else $error("upstream fixed bits wrong");

    property p_us_off;
        us_rd && page_code == 4'h0 |=> cfg_rdata == 32'h00000000;
    endproperty
    a_us_off: assert property (p_us_off)
        else $error("disabled upstream window not zero");

    property p_ds_mask;
        ds_rd |=> (cfg_rdata & ~$past(ds_upper_setup)) == 32'h00000000;
    endproperty
    a_ds_mask: assert property (p_ds_mask)
        else $error("masked upper bit reads one");

    property p_ds_claim;
        ds_claim |-> ds_enabled && $past(ds_req);
    endproperty
    a_ds_claim: assert property (p_ds_claim)
        else $error("downstream claim without request or enable");

    property p_ds_low;
        ds_claim |-> (($past(ds_low) ^ $past(ds_lower_base))
            & $past(ds_lower_setup) & 32'hFFFFF000) == 32'h00000000;
    endproperty
    a_ds_low: assert property (p_ds_low)
        else $error("downstream claim misses lower base");

    property p_us_claim;
        us_claim |-> us_enabled && $past(us_req);
    endproperty
    a_us_claim: assert property (p_us_claim)
        else $error("upstream claim without request or enable");

    property p_us_en;
        page_code == 4'h0 |=> !us_enabled;
    endproperty
    a_us_en: assert property (p_us_en)
        else $error("upstream enabled with page size off");

    property p_us_pipe;
        us_claim |=> us_xlat_valid && us_prefetch
            == ($past(lut_prefetch) && $past(page_code) != 4'h0);
    endproperty
    a_us_pipe: assert property (p_us_pipe)
        else $error("translation stage wrong");

    property p_rst;
        $fell(rst) |-> !ds_enabled && !us_enabled && !cfg_rvalid;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not idle after reset");

    c_us_rd: cover property (us_rd);
    c_ds_claim: cover property (ds_claim);
    c_us_xlat: cover property (us_xlat_valid);
endmodule

bind bwbr_window_regs bwbr_window_regs_props u_props (
    .clk, .rst, .cfg_secondary, .cfg_addr, .cfg_rd, .cfg_rvalid,
    .cfg_rdata, .ds_upper_setup, .ds_lower_setup, .ds_lower_base,
    .page_code, .ds_req, .ds_addr, .ds_claim, .ds_enabled, .us_req,
    .us_claim, .lut_prefetch, .us_xlat_valid, .us_prefetch, .us_enabled
);

`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Self-checking bench for the window base registers
// ------------------------------------------------------------
module testbench;
    import bwbr_pkg::*;

    logic            clk, rst, cfg_secondary, cfg_wr, cfg_rd, cfg_rvalid;
    logic [7:0]      cfg_addr;
    logic [3:0]      cfg_be;
    bwbr_page_code_t page_code;
    bwbr_word_t      cfg_wdata, cfg_rdata, ds_upper_setup, ds_lower_setup;
    bwbr_word_t      ds_lower_base, us_addr, lut_xlat_base, us_xlat_addr;
    logic            ds_req, ds_claim, ds_enabled, us_req, us_claim;
    logic            lut_prefetch, us_xlat_valid, us_prefetch, us_enabled;
    logic [63:0]     ds_addr;
    logic [5:0]      us_lut_index;
    int              n_mismatch = 0, n_compared = 0, cyc = 0;

    bwbr_window_regs #(.LUT_LOG(6)) u_bwbr_window_regs (
        .clk, .rst, .cfg_secondary, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be,
        .cfg_wdata, .cfg_rvalid, .cfg_rdata, .ds_upper_setup,
        .ds_lower_setup, .ds_lower_base, .page_code, .ds_req, .ds_addr,
        .ds_claim, .ds_enabled, .us_req, .us_addr, .us_claim,
        .us_lut_index, .lut_xlat_base, .lut_prefetch, .us_xlat_valid,
        .us_xlat_addr, .us_prefetch, .us_enabled
    );

    // Free-running 100 MHz clock
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // Counts, verdict and end of run
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One comparison, four-state exact
    task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Config write: one-cycle strobe launched at a falling edge
    task automatic wr(logic s, logic [7:0] a, logic [3:0] b, bwbr_word_t d);
        @(negedge clk);
        cfg_secondary = s;
        cfg_addr = a;
        cfg_be = b;
        cfg_wdata = d;
        cfg_wr = 1'h1;
        @(negedge clk);
        cfg_wr = 1'h0;
    endtask

    // Config read: answer stands exactly one cycle after the strobe
    task automatic rd(logic s, logic [7:0] a, bwbr_word_t e);
        @(negedge clk);
        cfg_secondary = s;
        cfg_addr = a;
        cfg_rd = 1'h1;
        @(negedge clk);
        cfg_rd = 1'h0;
        chk("cfg_rvalid", cfg_rvalid, 1);
        chk("cfg_rdata", cfg_rdata, e);
    endtask

    // Downstream address probe
    task automatic ds(logic [63:0] a, logic e);
        @(negedge clk);
        ds_req = 1'h1;
        ds_addr = a;
        @(negedge clk);
        ds_req = 1'h0;
        chk("ds_claim", ds_claim, e);
    endtask

    // Upstream probe; table answers during the claim cycle
    task automatic us(bwbr_word_t a, logic h, logic [5:0] ix,
                      bwbr_word_t xa, logic pf);
        @(negedge clk);
        us_req = 1'h1;
        us_addr = a;
        @(negedge clk);
        us_req = 1'h0;
        lut_xlat_base = 32'hABCDE000;
        lut_prefetch = pf;
        chk("us_claim", us_claim, h);
        if (h) begin
            chk("us_lut_index", us_lut_index, ix);
            @(negedge clk);
            chk("us_xlat_valid", us_xlat_valid, 1);
            chk("us_xlat_addr", us_xlat_addr, xa);
            chk("us_prefetch", us_prefetch, pf);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {cfg_secondary, cfg_wr, cfg_rd, ds_req, us_req, lut_prefetch} = '0;
        {cfg_addr, cfg_be, cfg_wdata, page_code, ds_addr, us_addr} = '0;
        {ds_upper_setup, ds_lower_setup, ds_lower_base} = '0;
        lut_xlat_base = 32'h00000000;
        rst = 1'h1;
        repeat (20) @(negedge clk);
        rst = 1'h0;
        // Reset contents at both offsets of both registers
        rd(1'h0, 8'h24, 32'h00000000);
        rd(1'h1, 8'h64, 32'h00000000);
        rd(1'h0, 8'h60, 32'h00000000);
        rd(1'h1, 8'h20, 32'h00000000);
        // Upper half: per-bit writeability, byte lanes
        ds_upper_setup = 32'hFFFF0F0F;
        wr(1'h0, 8'h24, 4'hF, 32'hFFFFFFFF);
        rd(1'h0, 8'h24, 32'hFFFF0F0F);
        wr(1'h1, 8'h64, 4'h1, 32'h00000000);
        rd(1'h1, 8'h64, 32'hFFFF0F00);
        rd(1'h0, 8'h28, 32'h00000000);
        // Downstream claim; low 12 bits never compared
        ds_upper_setup = 32'hFFFFFFFF;
        ds_lower_setup = 32'hFFFFFFFF;
        ds_lower_base = 32'h12345000;
        wr(1'h0, 8'h24, 4'hF, 32'h80000001);
        ds(64'h80000001_12345ABC, 1'h1);
        chk("ds_enabled", ds_enabled, 1);
        ds(64'h80000001_12346ABC, 1'h0);
        ds(64'h00000001_12345ABC, 1'h0);
        wr(1'h0, 8'h24, 4'hF, 32'h00000001);
        ds(64'h00000001_12345ABC, 1'h0);
        chk("ds_enabled", ds_enabled, 0);
        // Every nonzero page size code, written on one side, read on the other
        for (int c = 1; c < 16; c++) begin
            page_code = c[3:0];
            wr(c[0], c[0] ? 8'h20 : 8'h60, 4'hF, 32'hFFFFFFFF);
            rd(!c[0], c[0] ? 8'h60 : 8'h20,
               ((32'hFFFFFFFF << (13 + c)) & 32'hFFFFC000) | 32'h8);
        end
        page_code = 4'h0;
        rd(1'h0, 8'h60, 32'h00000000);
        // Smallest window: 256-byte pages, 64 entries
        page_code = 4'h1;
        wr(1'h0, 8'h60, 4'hF, 32'h40000000);
        us(32'h40001234, 1'h1, 6'h12, 32'hABCDE034, 1'h0);
        us(32'h40001234, 1'h1, 6'h12, 32'hABCDE034, 1'h1);
        us(32'h40004000, 1'h0, 6'h00, 32'h00000000, 1'h0);
        chk("us_enabled", us_enabled, 1);
        complete_run();
    end
endmodule

`default_nettype wire
